/* inc/brg_pkg.sv */
/*
  Constants and types shared by the bus-reset, root-holdoff and gap-count
  logic of the PHY and by the link-side driver of PHY register 1.
  Assumes one 20 MHz clock and an active-low asynchronous reset on both ends.
*/
// Overview of operation
// - Trigger bit written 1 starts bus reset
// - Trigger, holdoff, gap share register 1
// - Config packets load holdoff and gap, rx/tx
// - Two resets without update force gap 63
// - Register write keeps gap on own reset
// - Link resets bus after sending config packet
// - Follow-up reset rewrites sent packet values
// - Other resets write gap 63, keep holdoff
// - Register 1 written only with trigger set
package brg_pkg;
  localparam int unsigned GAP_W        = 6;
  localparam logic [5:0]  GAP_MAX      = 6'h3f;
  localparam logic [3:0]  REG1_ADDR    = 4'h1;
  localparam int unsigned REG1_TRIG_B  = 6;
  localparam int unsigned REG1_RHB_B   = 7;
  localparam int unsigned REG_W        = 8;
  localparam logic [7:0]  REG1_RST     = 8'h3f;
  localparam logic        HOLDOFF_RST  = 1'b0;
  localparam int unsigned RESET_CYC    = 4;

  typedef enum logic [2:0] {
    BRG_IDLE = 3'b001,
    BRG_RD   = 3'b010,
    BRG_WR   = 3'b100
  } brg_link_st_t;
endpackage : brg_pkg

/* inc/brg_if.sv */
/*
  Connection between the PHY register-1 logic and the link-side driver.
  Assumes both ends share clk_i; wr_stb, rd_stb and rd_valid are synchronous single-cycle strobes.
*/
`timescale 1ns/10ps
`default_nettype none
interface brg_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rd_valid;
  logic       bus_reset;

  modport phy (
    input  wr_stb, rd_stb, addr, wdata,
    output rdata, rd_valid, bus_reset
  );
  modport link (
    output wr_stb, rd_stb, addr, wdata,
    input  rdata, rd_valid, bus_reset
  );
endinterface : brg_if
`default_nettype wire

/* core/brg_phy.sv */
/*
  PHY side: register 1 (trigger, holdoff flag, gap count), config-packet
  loading, consecutive-reset tracking and bus reset generation.
  Assumes config-packet and external reset events arrive as one-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none
module brg_phy
  import brg_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  brg_if.phy                    reg_if,
  input  wire logic             cfg_pkt_i,
  input  wire logic             cfg_holdoff_i,
  input  wire logic [GAP_W-1:0] cfg_gap_i,
  input  wire logic             ext_reset_i,
  output logic                  bus_reset_o,
  output logic                  root_holdoff_flag_o,
  output logic [GAP_W-1:0]      gap_count_o
);
  import brg_pkg::*;

  logic             holdoff_r, holdoff_nxt;
  logic [GAP_W-1:0] gap_r, gap_nxt;
  logic             consec_r, consec_nxt;
  logic [2:0]       rst_cnt_r, rst_cnt_nxt;
  logic [7:0]       rdata_r, rdata_nxt;
  logic             rvld_r, rvld_nxt;
  logic             reg1_wr, trig_wr, rst_start;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    reg1_wr     = reg_if.wr_stb && (reg_if.addr == REG1_ADDR);
    trig_wr     = reg1_wr && reg_if.wdata[REG1_TRIG_B];
    rst_start   = trig_wr || ext_reset_i;
    holdoff_nxt = holdoff_r;
    gap_nxt     = gap_r;
    consec_nxt  = consec_r;
    rst_cnt_nxt = (rst_cnt_r != 3'h0) ? rst_cnt_r - 3'h1 : 3'h0;
    if (rst_start) begin
      rst_cnt_nxt = 3'(RESET_CYC);
    end
    if (ext_reset_i && !reg1_wr && !cfg_pkt_i) begin
      if (consec_r) begin
        gap_nxt = GAP_MAX;
      end
      consec_nxt = 1'b1;
    end
    if (cfg_pkt_i) begin
      holdoff_nxt = cfg_holdoff_i;
      gap_nxt     = cfg_gap_i;
      consec_nxt  = 1'b0;
    end
    if (reg1_wr) begin
      holdoff_nxt = reg_if.wdata[REG1_RHB_B];
      gap_nxt     = reg_if.wdata[GAP_W-1:0];
      consec_nxt  = trig_wr;
    end
    if (ext_reset_i && (reg1_wr || cfg_pkt_i)) begin
      consec_nxt = 1'b1;
    end
    rvld_nxt  = reg_if.rd_stb;
    rdata_nxt = 8'h00;
    if (reg_if.rd_stb && (reg_if.addr == REG1_ADDR)) begin
      rdata_nxt = {holdoff_r, 1'b0, gap_r};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      holdoff_r <= HOLDOFF_RST;
      gap_r     <= REG1_RST[GAP_W-1:0];
      consec_r  <= 1'b0;
      rst_cnt_r <= 3'h0;
      rdata_r   <= 8'h00;
      rvld_r    <= 1'b0;
    end else begin
      holdoff_r <= holdoff_nxt;
      gap_r     <= gap_nxt;
      consec_r  <= consec_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      rdata_r   <= rdata_nxt;
      rvld_r    <= rvld_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pulse is registered, so it trails the trigger by one cycle
  logic busrst_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busrst_r <= 1'b0;
    end else begin
      busrst_r <= (rst_cnt_nxt != 3'h0);
    end
  end

  assign reg_if.rdata       = rdata_r;
  assign reg_if.rd_valid    = rvld_r;
  assign reg_if.bus_reset   = busrst_r;
  assign bus_reset_o        = busrst_r;
  assign root_holdoff_flag_o = holdoff_r;
  assign gap_count_o        = gap_r;
endmodule : brg_phy
`default_nettype wire

/* core/brg_link.sv */
/*
  Link side: issues bus resets through register 1 with the write contents
  that keep gap counts consistent across the bus.
  Assumes the PHY answers a read one cycle after the read strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module brg_link
  import brg_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  brg_if.link       reg_if,
  input  wire logic cfg_sent_i,
  input  wire logic reset_req_i,
  output logic      busy_o
);
  import brg_pkg::*;

  brg_link_st_t st_r, st_nxt;
  logic         after_cfg_r, after_cfg_nxt;
  logic         wr_r, wr_nxt, rd_r, rd_nxt;
  logic [7:0]   wd_r, wd_nxt;
  logic         busy_r, busy_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt        = st_r;
    after_cfg_nxt = after_cfg_r | cfg_sent_i;
    wr_nxt        = 1'b0;
    rd_nxt        = 1'b0;
    wd_nxt        = wd_r;
    case (st_r)
      BRG_IDLE: begin
        if (cfg_sent_i || reset_req_i || after_cfg_r) begin
          st_nxt = BRG_RD;
          rd_nxt = 1'b1;
        end
      end
      BRG_RD: begin
        if (reg_if.rd_valid) begin
          st_nxt = BRG_WR;
          wr_nxt = 1'b1;
          wd_nxt = reg_if.rdata;
          wd_nxt[REG1_TRIG_B] = 1'b1;
          if (!after_cfg_r) begin
            wd_nxt[GAP_W-1:0] = GAP_MAX;
          end
          after_cfg_nxt = cfg_sent_i;
        end
      end
      BRG_WR: begin
        st_nxt = BRG_IDLE;
      end
      default: begin
        st_nxt = BRG_IDLE;
      end
    endcase
    // Registered so the output comes straight from a flop
    busy_nxt = (st_nxt != BRG_IDLE);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r        <= BRG_IDLE;
      after_cfg_r <= 1'b0;
      wr_r        <= 1'b0;
      rd_r        <= 1'b0;
      wd_r        <= 8'h00;
      busy_r      <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      after_cfg_r <= after_cfg_nxt;
      wr_r        <= wr_nxt;
      rd_r        <= rd_nxt;
      wd_r        <= wd_nxt;
      busy_r      <= busy_nxt;
    end
  end

  assign reg_if.wr_stb = wr_r;
  assign reg_if.rd_stb = rd_r;
  assign reg_if.addr   = REG1_ADDR;
  assign reg_if.wdata  = wd_r;
  assign busy_o        = busy_r;
endmodule : brg_link
`default_nettype wire

/* tb/brg_chk.sv */
/*
  Checker on the register-1 wires between the two ends.
  Assumes one clock and the active-low reset of both ends.
*/
`timescale 1ns/10ps
`default_nettype none
module brg_chk (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rd_valid,
  input wire logic       bus_reset
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Read then answer one cycle later
  sequence rd_ans_s;
    rd_stb ##1 rd_valid;
  endsequence
  trig_reset_a: assert property (wr_stb && wdata[6] |=> bus_reset)
    else $error("trigger gave no reset");
  reset_len_a: assert property ($rose(bus_reset) |-> bus_reset[*4] ##1 !bus_reset)
    else $error("reset length wrong");
  rd_layout_a: assert property (rd_valid |-> rdata[6] == 1'b0)
    else $error("read layout wrong");
  wr_trig_a: assert property (wr_stb |-> wdata[6] && addr == 4'h1)
    else $error("write without trigger");
  link_order_a: assert property (rd_stb |-> rd_ans_s ##1 wr_stb)
    else $error("no write after read");
  rd_answer_a: assert property (rd_valid |-> $past(rd_stb))
    else $error("stray read answer");
  keep_flag_a: assert property (wr_stb |-> wdata[7] == $past(rdata[7]))
    else $error("holdoff not kept");
  gap_val_a: assert property (wr_stb |-> wdata[5:0] == 6'h3f || wdata[5:0] == $past(rdata[5:0]))
    else $error("gap write wrong");
endmodule : brg_chk
`default_nettype wire

/* tb/test_phy_bus_reset_gap_control.sv */
/*
  Bench: drives both ends through packets, cable resets and requests.
  Assumes the design and checker files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_phy_bus_reset_gap_control;
  import brg_pkg::*;
  logic             clk_i, rst_n_i, cfg_pkt_i, cfg_holdoff_i, ext_reset_i;
  logic             cfg_sent_i, reset_req_i, bus_reset_o, root_holdoff_flag_o, busy_o;
  logic [GAP_W-1:0] cfg_gap_i, gap_count_o;
  int               fails, comparisons;
  brg_if reg_if ();
  brg_phy i_brg_phy (.clk_i, .rst_n_i, .reg_if(reg_if.phy), .cfg_pkt_i, .cfg_holdoff_i,
    .cfg_gap_i, .ext_reset_i, .bus_reset_o, .root_holdoff_flag_o, .gap_count_o);
  brg_link i_brg_link (.clk_i, .rst_n_i, .reg_if(reg_if.link), .cfg_sent_i, .reset_req_i,
    .busy_o);
  brg_chk i_brg_chk (.clk_i, .rst_n_i, .wr_stb(reg_if.wr_stb), .rd_stb(reg_if.rd_stb),
    .addr(reg_if.addr), .wdata(reg_if.wdata), .rdata(reg_if.rdata),
    .rd_valid(reg_if.rd_valid), .bus_reset(reg_if.bus_reset));
  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task chk(input string n, input logic [6:0] e);
    comparisons++;
    if ({root_holdoff_flag_o, gap_count_o} !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, {root_holdoff_flag_o, gap_count_o});
    end
  endtask : chk
  // v = {packet, sent, request, cable, holdoff}; long idle lets sequences finish
  // r = bus reset cycles expected in the window
  task act(input logic [4:0] v, input logic [5:0] g, input int r);
    int n;
    n = 0;
    @(posedge clk_i);
    {cfg_pkt_i, cfg_sent_i, reset_req_i, ext_reset_i, cfg_holdoff_i} <= v;
    cfg_gap_i <= g;
    @(posedge clk_i);
    {cfg_pkt_i, cfg_sent_i, reset_req_i, ext_reset_i} <= 4'h0;
    repeat (12) begin
      @(posedge clk_i);
      if (bus_reset_o === 1'b1) n++;
    end
    comparisons += 2;
    if (n != r) begin
      fails++;
      $display("[ERR] bus_reset_o cycles exp %0d got %0d", r, n);
    end
    if (busy_o !== 1'b0) begin
      fails++;
      $display("[ERR] busy_o exp 0 got %b", busy_o);
    end
  endtask : act
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    #40000;
    fails++;
    report_and_stop();
  end
  initial begin
    {cfg_pkt_i, cfg_sent_i, reset_req_i, ext_reset_i, cfg_holdoff_i, rst_n_i} = 6'h00;
    cfg_gap_i = 6'h00;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk("reset", 7'h3f);
    act(5'h11, 6'h05, 0); chk("rx load", 7'h45);
    act(5'h08, 6'h05, 4); chk("own reset", 7'h45);
    act(5'h02, 6'h05, 4); chk("cable after own", 7'h7f);
    act(5'h10, 6'h0a, 0); chk("tx load", 7'h0a);
    act(5'h02, 6'h0a, 4); chk("one cable", 7'h0a);
    act(5'h02, 6'h0a, 4); chk("two cables", 7'h3f);
    act(5'h11, 6'h10, 0);
    act(5'h04, 6'h10, 4); chk("plain request", 7'h7f);
    report_and_stop();
  end
endmodule : test_phy_bus_reset_gap_control
`default_nettype wire
